// [inc/tec_consts.svh]
// Constants of the eight-bit timer/event counter: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH

// Register byte addresses
`define TEC_ADDR_CTRL      8'h00
`define TEC_ADDR_COUNT     8'h04
`define TEC_ADDR_STATUS    8'h08
// Control field positions
`define TEC_MODE_HI        7
`define TEC_MODE_LO        6
`define TEC_ENABLE_BIT     4
`define TEC_EDGE_BIT       3
`define TEC_PSC_HI         2
`define TEC_PSC_LO         0
// Status field positions
`define TEC_FLAG_BIT       0
`define TEC_SLEEP_BIT      1
// Control reset value: edge select set, all else clear
`define TEC_CTRL_RESET     8'h08
// Implemented control bits (bit 5 reads zero)
`define TEC_CTRL_MASK      8'hDF
// Lowest prescale power and power of the top code
`define TEC_PSC_BASE_POW   3
`define TEC_PSC_TOP_POW    10
// Width of the low-speed divider chain
`define TEC_DIV_WIDTH      11

`endif

// [inc/tec_pkg.sv]
// Types of the eight-bit timer/event counter.
// Assumes the constants header is compiled alongside.
package tec_pkg;

   // Operating mode field encodings
   typedef enum logic [1:0] {
      TEC_MODE_UNUSED = 2'h0,
      TEC_MODE_EVENT  = 2'h1,
      TEC_MODE_TIMER  = 2'h2,
      TEC_MODE_PULSE  = 2'h3
   } tec_mode_t;

   // Control register layout
   typedef struct packed {
      tec_mode_t  operating_mode_field;
      logic       unused_bit;
      logic       count_enable;
      logic       active_edge_select;
      logic [2:0] prescale_select;
   } tec_ctrl_t;

   // Wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } tec_wb_req_t;

endpackage : tec_pkg

// [logic/tec_prescaler.sv]
// Prescaler of the low-speed tick into one counting strobe.
// Assumes lirc_tick_i is a one-cycle pulse per low-speed clock period.
`timescale 1ns/1ps
`include "tec_consts.svh"

module tec_prescaler
   import tec_pkg::*;
#(
   parameter int DIV_WIDTH = `TEC_DIV_WIDTH
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Tick and select
   input  wire logic       lirc_tick_i,
   input  wire logic [2:0] prescale_select_i,
   // Strobe on each falling edge of the selected tap
   output logic            fall_o
);

   // Selected power of two for each code
   function automatic int tec_tap(input logic [2:0] code);
      if (code == 3'h7) begin
         return `TEC_PSC_TOP_POW;
      end
      return `TEC_PSC_BASE_POW + int'(code);
   endfunction : tec_tap

   typedef struct packed {
      logic [DIV_WIDTH-1:0] div;
      logic                 tap_q;
      logic                 fall;
   } tec_psc_state_t;

   tec_psc_state_t state, next_state;
   logic           tap_now;

   // Divider chain; tap bit n-1 toggles at tick/2^n
   always_comb begin
      next_state = state;
      if (lirc_tick_i) begin
         next_state.div = state.div + 1'b1;
      end
      tap_now = next_state.div[tec_tap(prescale_select_i) - 1];
      next_state.tap_q = tap_now;
      next_state.fall  = state.tap_q & ~tap_now;
   end

   // State register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign fall_o = state.fall;

endmodule : tec_prescaler

// [logic/tec_timer.sv]
// Eight-bit timer/event counter with preload and Wishbone register access.
// Assumes external_count_input_i and lirc_tick_i are synchronous to clk_i.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tec_consts.svh"

module tec_timer
   import tec_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Time source, external count pin and sleep status
   input  wire logic        lirc_tick_i,
   input  wire logic        external_count_input_i,
   input  wire logic        sleep_i,
   // Wake-up and overflow flag
   output logic             wake_o,
   output logic             overflow_request_flag_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      tec_ctrl_t   ctrl;
      logic [7:0]  preload;
      logic [7:0]  count;
      logic        flag;
      logic        pin_q;
      logic        measuring;
      logic        ack;
      logic [31:0] rdata;
      logic        wake;
   } tec_state_t;

   tec_state_t  state, next_state;
   tec_wb_req_t req;
   logic        psc_fall;
   logic        req_new;
   logic        rd_count;
   logic        pin_rise;
   logic        pin_fall;
   logic        start_edge;
   logic        stop_edge;
   logic        tick;
   logic        overflow;
   logic        wr_ctrl;
   logic        wr_count;
   logic        wr_status;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   tec_prescaler #(
      .DIV_WIDTH(`TEC_DIV_WIDTH)
   ) u_psc (
      .clk_i            (clk_i),
      .nrst_i           (nrst_i),
      .lirc_tick_i      (lirc_tick_i),
      .prescale_select_i(state.ctrl.prescale_select),
      .fall_o           (psc_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Request aimed at one register word
   function automatic logic tec_hit(input tec_wb_req_t r, input logic [7:0] a);
      return r.cyc & r.stb & (r.adr == a);
   endfunction : tec_hit

   // Pin edge picked by the edge select bit
   function automatic logic tec_pick(input logic sel, input logic zero_edge,
                                     input logic one_edge);
      return sel ? one_edge : zero_edge;
   endfunction : tec_pick

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // Bundle the request and find a fresh access
   always_comb begin
      req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
              adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
      req_new   = req.cyc & req.stb & ~state.ack;
      wr_ctrl   = req_new & req.we & req.sel[0] & tec_hit(req, `TEC_ADDR_CTRL);
      wr_count  = req_new & req.we & req.sel[0] & tec_hit(req, `TEC_ADDR_COUNT);
      wr_status = req_new & req.we & req.sel[0] & tec_hit(req, `TEC_ADDR_STATUS);
      // Clock blocked for any read cycle of the count register
      rd_count  = tec_hit(req, `TEC_ADDR_COUNT) & ~req.we;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count source selection

   // Pin edges and the mode-dependent counting tick
   always_comb begin
      pin_rise   = ~state.pin_q & external_count_input_i;
      pin_fall   = state.pin_q & ~external_count_input_i;
      start_edge = tec_pick(state.ctrl.active_edge_select, pin_fall, pin_rise);
      stop_edge  = tec_pick(state.ctrl.active_edge_select, pin_rise, pin_fall);
      tick       = 1'b0;
      unique case (state.ctrl.operating_mode_field)
         TEC_MODE_UNUSED: tick = 1'b0;
         // Sleep does not gate the event source
         TEC_MODE_EVENT: tick = tec_pick(state.ctrl.active_edge_select,
                                         pin_rise, pin_fall);
         TEC_MODE_TIMER: tick = psc_fall;
         TEC_MODE_PULSE: tick = psc_fall & state.measuring;
      endcase
      tick     = tick & state.ctrl.count_enable & ~rd_count;
      overflow = tick & (state.count == 8'hFF);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_state       = state;
      next_state.pin_q = external_count_input_i;
      next_state.ack   = req_new;
      next_state.wake  = overflow;

      // Counting and overflow reload
      if (overflow) begin
         next_state.count = state.preload;
      end else if (tick) begin
         next_state.count = state.count + 8'h01;
      end

      // Pulse measurement arming, start and end
      if (state.ctrl.operating_mode_field == TEC_MODE_PULSE && state.ctrl.count_enable) begin
         if (!state.measuring && start_edge) begin
            next_state.measuring = 1'b1;
         end else if (state.measuring && stop_edge) begin
            next_state.measuring         = 1'b0;
            next_state.ctrl.count_enable = 1'b0;
         end
      end else begin
         next_state.measuring = 1'b0;
      end

      // Control write; software write wins over the hardware clear
      if (wr_ctrl) begin
         next_state.ctrl = tec_ctrl_t'(req.dat[7:0] & `TEC_CTRL_MASK);
         next_state.measuring = 1'b0;
      end

      // Count register write
      if (wr_count) begin
         next_state.preload = req.dat[7:0];
         if (!state.ctrl.count_enable) begin
            next_state.count = req.dat[7:0];
         end
      end

      // Flag: software write, then hardware set wins
      if (wr_status) begin
         next_state.flag = req.dat[`TEC_FLAG_BIT];
      end
      if (overflow) begin
         next_state.flag = 1'b1;
      end

      // Read data
      next_state.rdata = 32'h0000_0000;
      if (req_new && !req.we) begin
         if (req.adr == `TEC_ADDR_CTRL) begin
            next_state.rdata[7:0] = state.ctrl & `TEC_CTRL_MASK;
         end else if (req.adr == `TEC_ADDR_COUNT) begin
            next_state.rdata[7:0] = state.count;
         end else if (req.adr == `TEC_ADDR_STATUS) begin
            next_state.rdata[`TEC_FLAG_BIT]  = state.flag;
            next_state.rdata[`TEC_SLEEP_BIT] = sleep_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state      <= '0;
         state.ctrl <= tec_ctrl_t'(`TEC_CTRL_RESET);
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flip-flops
   assign wb_dat_o                = state.rdata;
   assign wb_ack_o                = state.ack;
   assign wake_o                  = state.wake;
   assign overflow_request_flag_o = state.flag;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_overflow_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
      overflow |=> (state.count == $past(state.preload)) && state.flag)
      else $error("overflow did not reload and flag");

   a_unused_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_UNUSED && !wr_count)
      |=> state.count == $past(state.count))
      else $error("counter moved in unused mode");

   a_read_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (rd_count && !wr_count) |=> $stable(state.count))
      else $error("counter changed during read");

   a_enabled_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_count && state.ctrl.count_enable && !tick) |=> $stable(state.count))
      else $error("enabled write touched counter");

   a_disabled_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_count && !state.ctrl.count_enable)
      |=> state.count == state.preload && state.count == $past(wb_dat_i[7:0]))
      else $error("disabled write not loaded");

   a_enable_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.count_enable && !wr_ctrl
       && state.ctrl.operating_mode_field != TEC_MODE_PULSE)
      |=> state.ctrl.count_enable)
      else $error("enable cleared without software");

   a_pulse_end: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.measuring && stop_edge && !wr_ctrl)
      |=> !state.ctrl.count_enable && !state.measuring)
      else $error("pulse end did not clear enable");

   a_wake_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wake_o |-> $past(overflow) && overflow_request_flag_o)
      else $error("wake without overflow");

   a_count_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (!state.ctrl.count_enable && !wr_count) |=> $stable(state.count))
      else $error("counted while disabled");

   a_bit5_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wb_ack_o && $past(req.adr) == `TEC_ADDR_CTRL) |-> wb_dat_o[5] == 1'b0)
      else $error("bit 5 read nonzero");

   // Counting steps per source
   a_event_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_EVENT && state.ctrl.count_enable
       && !rd_count && state.count != 8'hFF
       && (state.ctrl.active_edge_select ? pin_fall : pin_rise))
      |=> state.count == $past(state.count) + 8'h01)
      else $error("event edge not counted");

   a_timer_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_TIMER && state.ctrl.count_enable
       && !rd_count && state.count != 8'hFF && psc_fall)
      |=> state.count == $past(state.count) + 8'h01)
      else $error("timer fall not counted");

   // Pulse measurement arming, start and end
   a_pulse_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_PULSE && !state.measuring && !wr_count)
      |=> $stable(state.count))
      else $error("counted before pulse start");

   a_pulse_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_PULSE && state.ctrl.count_enable
       && !state.measuring && !wr_ctrl
       && (state.ctrl.active_edge_select ? pin_rise : pin_fall))
      |=> state.measuring)
      else $error("start edge did not arm count");

   a_measure_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
      state.measuring
      |-> state.ctrl.operating_mode_field == TEC_MODE_PULSE && state.ctrl.count_enable)
      else $error("measuring outside armed pulse mode");

   a_enable_fall: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ($fell(state.ctrl.count_enable) && !$past(wr_ctrl))
      |-> $past(state.measuring) && $past(stop_edge))
      else $error("enable cleared without pulse end");

   a_one_shot: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state.ctrl.operating_mode_field == TEC_MODE_PULSE && !state.ctrl.count_enable)
      |=> !state.measuring)
      else $error("measurement restarted without enable");

   // Register writes, reads and wake-up
   a_flag_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_status && !overflow)
      |=> overflow_request_flag_o == $past(wb_dat_i[`TEC_FLAG_BIT]))
      else $error("flag write not taken");

   a_preload_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_count |=> state.preload == $past(wb_dat_i[7:0]))
      else $error("preload write not taken");

   a_ctrl_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_ctrl
      |=> state.ctrl == tec_ctrl_t'($past(wb_dat_i[7:0]) & `TEC_CTRL_MASK))
      else $error("control write not taken");

   a_read_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (req_new && rd_count) |=> wb_dat_o[7:0] == $past(state.count))
      else $error("count read wrong value");

   a_wake_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
      overflow |=> wake_o)
      else $error("overflow gave no wake");

   // Values seen at the first edge after reset release
   a_reset_ctrl: assert property (@(posedge clk_i)
      $rose(nrst_i)
      |-> state.ctrl == tec_ctrl_t'(`TEC_CTRL_RESET) && !state.flag)
      else $error("control not at reset value");

endmodule : tec_timer

// [verif/tec_pin_src.sv]
// Partner model: source of edges and pulses on the count pin.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

module tec_pin_src (
   // Clock
   input  wire logic clk_i,
   // Count pin level
   output logic      pin_o
);
   initial pin_o = 1'b0;

   // Park the pin at a level between pulses
   task automatic level(input logic v);
      @(posedge clk_i);
      pin_o <= v;
   endtask : level

   // One pulse away from idle, width and gap in clock cycles
   task automatic pulse(input logic idle, input int width, input int gap);
      @(posedge clk_i);
      pin_o <= ~idle;
      repeat (width) @(posedge clk_i);
      pin_o <= idle;
      repeat (gap) @(posedge clk_i);
   endtask : pulse
endmodule : tec_pin_src

// [verif/eight_bit_timer_event_counter_bench.sv]
// Self-checking bench of the timer/event counter over classic Wishbone.
// Assumes the pin source model and the design compile before it.
`timescale 1ns/1ps
`include "tec_consts.svh"

module eight_bit_timer_event_counter_bench
   import tec_pkg::*;
;
   logic        clk_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, wb_dat_o;
   logic        wb_ack_o, tick = 1'b0, sleep = 1'b0, pin, wake_o, flag_o;
   logic [7:0]  rd, prev;
   logic [23:0] hi;
   int          err_count = 0, checks = 0, wakes = 0;

   ////////////////////////////////////////////////////////////////////
   // Clock, tick every other cycle, wake pulse monitor
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) tick <= ~tick;
   always @(posedge clk_i) if (wake_o === 1'b1) wakes++;

   tec_pin_src src (.clk_i(clk_i), .pin_o(pin));
   tec_timer dut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .lirc_tick_i(tick), .external_count_input_i(pin),
      .sleep_i(sleep), .wake_o(wake_o), .overflow_request_flag_o(flag_o));

   ////////////////////////////////////////////////////////////////////
   // Bus cycles and comparisons
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      hi = wb_dat_o[31:8];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb_cycle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb_cycle(1'b1, a, d);
   endtask : wr

   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : check

   task automatic check_rng(input string n, input int lo, input int hi, input logic [7:0] g);
      checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         err_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : check_rng

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      wb_cycle(1'b0, a, 8'h00);
      check("register read", e, rd);
      check("upper read bits", 8'h00, {7'h0, |hi});
   endtask : rdchk

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      rdchk(`TEC_ADDR_CTRL, 8'h08);
      wr(`TEC_ADDR_CTRL, 8'hFF);
      rdchk(`TEC_ADDR_CTRL, 8'hDF);
      wr(`TEC_ADDR_CTRL, 8'h90);
      wr(`TEC_ADDR_CTRL, 8'h80);
      rdchk(8'h0C, 8'h00);
   endtask : t_regs

   task automatic t_event();
      wr(`TEC_ADDR_CTRL, 8'h40);
      wr(`TEC_ADDR_COUNT, 8'hFD);
      wr(`TEC_ADDR_CTRL, 8'h50);
      repeat (3) src.pulse(1'b0, 3, 3);
      check("flag", 8'h01, {7'h0, flag_o});
      rdchk(`TEC_ADDR_COUNT, 8'hFD);
      wr(`TEC_ADDR_COUNT, 8'h10);
      rdchk(`TEC_ADDR_COUNT, 8'hFD);
      sleep <= 1'b1;
      wr(`TEC_ADDR_CTRL, 8'h58);
      repeat (3) src.pulse(1'b0, 3, 3);
      rdchk(`TEC_ADDR_COUNT, 8'h10);
      rdchk(`TEC_ADDR_CTRL, 8'h58);
      check("wakes", 8'h02, wakes[7:0]);
      rdchk(`TEC_ADDR_STATUS, 8'h03);
      sleep <= 1'b0;
      wr(`TEC_ADDR_STATUS, 8'h00);
      check("flag", 8'h00, {7'h0, flag_o});
      rdchk(`TEC_ADDR_STATUS, 8'h00);
   endtask : t_event

   task automatic t_hold(input logic [7:0] c);
      wr(`TEC_ADDR_CTRL, 8'h40);
      wr(`TEC_ADDR_COUNT, 8'h33);
      wr(`TEC_ADDR_CTRL, c);
      repeat (4) src.pulse(1'b0, 20, 20);
      rdchk(`TEC_ADDR_COUNT, 8'h33);
   endtask : t_hold

   task automatic t_timer(input logic [2:0] c);
      wr(`TEC_ADDR_CTRL, {5'h10, c});
      wr(`TEC_ADDR_COUNT, 8'h00);
      wr(`TEC_ADDR_CTRL, {5'h12, c});
      repeat (8 << (3 + c)) @(posedge clk_i);
      wr(`TEC_ADDR_CTRL, {5'h10, c});
      wb_cycle(1'b0, `TEC_ADDR_COUNT, 8'h00);
      check_rng("timer count", 4, 5, rd);
   endtask : t_timer

   task automatic t_pulse(input logic e, input logic [7:0] s, input int n, input int lo,
                          input int hi);
      src.level(~e);
      wr(`TEC_ADDR_CTRL, {4'hC, e, 3'h0});
      wr(`TEC_ADDR_COUNT, s);
      wr(`TEC_ADDR_CTRL, {4'hD, e, 3'h0});
      repeat (40) @(posedge clk_i);
      rdchk(`TEC_ADDR_COUNT, s);
      src.pulse(~e, 16 * n, 20);
      rdchk(`TEC_ADDR_CTRL, {4'hC, e, 3'h0});
      wb_cycle(1'b0, `TEC_ADDR_COUNT, 8'h00);
      prev = rd;
      check_rng("pulse count", lo, hi, rd);
      src.pulse(~e, 64, 20);
      rdchk(`TEC_ADDR_COUNT, prev);
   endtask : t_pulse

   ////////////////////////////////////////////////////////////////////
   // Closing, watchdog and main sequence
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   initial begin
      #(8 * 80000);
      err_count++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_event();
      t_hold(8'h10);
      t_hold(8'h40);
      for (int c = 0; c < 8; c++) t_timer(c[2:0]);
      t_pulse(1'b0, 8'h00, 8, 7, 9);
      t_pulse(1'b1, 8'hF8, 12, 8'hFB, 8'hFD);
      check("flag", 8'h01, {7'h0, flag_o});
      check("wakes", 8'h03, wakes[7:0]);
      end_sim();
   end
endmodule : eight_bit_timer_event_counter_bench
